/* File: src/pbr_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbr_map.svh"
// Functional notes
// - Each peripheral input owns a selection register choosing its pin.
// - Selection fields are four bits wide.
// - Field value n, 0 to 14, connects remappable pin n to the owning peripheral input.
// - Each port register has clear, set, invert aliases at +0x4, +0x8, +0xC.
// - Reduced-pin variant resets direction to 0x0000EFBF.
// - Pin value and latch have no guaranteed reset contents.
// - Unimplemented bits, all upper sixteen bits, read zero and ignore writes.
// - Remappable inputs have no default pin until assigned.
// - Remapped peripheral beats other digital pin functions, never analog ones.
module pbr_port #(
  parameter bit REDUCED_PINS = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] pin_in,
  output pbr_pkg::pbr_pad_t pad,
  output pbr_pkg::pbr_pad_cfg_t pad_cfg,
  output logic [`PBR_NUM_IN-1:0] periph_in
);
  localparam logic [15:0] IMASK = REDUCED_PINS ? `PBR_MASK_REDUCED : `PBR_MASK_FULL;
  localparam logic [15:0] AMASK = `PBR_ANSEL_MASK & IMASK;

  logic [15:0] anlg_r;
  logic [15:0] dir_r;
  logic [15:0] lat_r;
  logic [15:0] odc_r;
  logic [15:0] pu_r;
  logic [15:0] pd_r;
  logic [15:0] cncon_r;
  logic [15:0] cnen_r;
  logic [15:0] cnstat_r;
  logic [15:0] prev_r;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic [15:0] sync3_r;
  logic [15:0] filt_r;
  logic [`PBR_NUM_IN*`PBR_SEL_W-1:0] sel_r;
  logic [15:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic do_write;
  logic do_read;
  logic [15:0] dig_in;
  logic [15:0] claimed;
  logic [15:0] drive;
  logic [15:0] cn_set;
  logic cn_clr;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  pbr_pkg::pbr_op_t wr_op;
  logic [11:0] wr_reg;
  logic [2:0] wr_sel;

  // Applies a base or alias write under byte strobes and the implemented mask.
  function automatic logic [15:0] apply_wr(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb,
    input pbr_pkg::pbr_op_t op,
    input logic [15:0] mask
  );
    logic [15:0] m;
    logic [15:0] d;
    m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    d = wd[15:0] & m;
    case (op)
      pbr_pkg::pbr_op_clr: apply_wr = old & ~d;
      pbr_pkg::pbr_op_set: apply_wr = old | d;
      pbr_pkg::pbr_op_inv: apply_wr = old ^ d;
      default: apply_wr = (old & ~m) | d;
    endcase
  endfunction

  // True when a byte address names a port register, alias, or selection word.
  function automatic logic is_mapped(input logic [15:0] a);
    logic port_hit;
    logic sel_hit;
    port_hit = (a[15:4] >= `PBR_ANSEL_OFS >> 4) && (a[15:4] <= `PBR_CNSTAT_OFS >> 4);
    sel_hit = (a[15:5] == `PBR_SEL_PAGE);
    is_mapped = (a[1:0] == 2'h0) && (port_hit || sel_hit);
  endfunction

  // Write address and data are taken independently and held until both exist.
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_op = pbr_pkg::pbr_op_t'(awaddr_r[3:2]);
  assign wr_reg = awaddr_r[15:4];
  assign wr_sel = awaddr_r[4:2];
  assign wr_ok = is_mapped(awaddr_r);

  // Write channel holding registers and the write response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 16'h0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; aliases apply to every port register except the change status, which ignores writes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      anlg_r <= `PBR_ANSEL_RST & AMASK;
      dir_r <= IMASK;
      lat_r <= `PBR_ZERO_RST;
      odc_r <= `PBR_ZERO_RST;
      pu_r <= `PBR_ZERO_RST;
      pd_r <= `PBR_ZERO_RST;
      cncon_r <= `PBR_ZERO_RST;
      cnen_r <= `PBR_ZERO_RST;
      sel_r <= {`PBR_NUM_IN{`PBR_SEL_NONE}};
    end
    else if (do_write && wr_ok)
    begin
      case (wr_reg)
        `PBR_ANSEL_OFS >> 4: anlg_r <= apply_wr(anlg_r, wdata_r, wstrb_r, wr_op, AMASK);
        `PBR_DIR_OFS >> 4: dir_r <= apply_wr(dir_r, wdata_r, wstrb_r, wr_op, IMASK);
        // Writes to the pin value register land in the output latch.
        `PBR_PIN_OFS >> 4,
        `PBR_LAT_OFS >> 4: lat_r <= apply_wr(lat_r, wdata_r, wstrb_r, wr_op, IMASK);
        `PBR_ODC_OFS >> 4: odc_r <= apply_wr(odc_r, wdata_r, wstrb_r, wr_op, IMASK);
        `PBR_PU_OFS >> 4: pu_r <= apply_wr(pu_r, wdata_r, wstrb_r, wr_op, IMASK);
        `PBR_PD_OFS >> 4: pd_r <= apply_wr(pd_r, wdata_r, wstrb_r, wr_op, IMASK);
        `PBR_CNCON_OFS >> 4:
          cncon_r <= apply_wr(cncon_r, wdata_r, wstrb_r, wr_op, `PBR_CNCON_MASK);
        `PBR_CNEN_OFS >> 4: cnen_r <= apply_wr(cnen_r, wdata_r, wstrb_r, wr_op, IMASK);
        default:
        begin
          // Selection words take a plain write of their low field.
          if ((wr_reg[11:1] == `PBR_SEL_PAGE) && wstrb_r[0])
            sel_r[wr_sel*`PBR_SEL_W +: `PBR_SEL_W] <= wdata_r[`PBR_SEL_W-1:0];
        end
      endcase
    end
  end

  // Pin inputs pass three flops; a change counts once stages two and three agree.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
      sync3_r <= 16'h0000;
      filt_r <= 16'h0000;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
    end
  end

  // Analog-selected pins present zero on the digital input path.
  assign dig_in = filt_r & ~anlg_r & IMASK;

  pbr_input_router u_router (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_level(dig_in),
    .pin_usable(IMASK & ~anlg_r),
    .sel_flat(sel_r),
    .periph_in(periph_in),
    .pin_claimed(claimed)
  );

  // A claimed pin stops driving so the remapped input owns it.
  assign drive = ~dir_r & ~claimed & IMASK;

  // Pad drive and configuration, registered; open drain only pulls low.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad <= '0;
      pad_cfg <= '0;
    end
    else
    begin
      pad.out <= lat_r & ~odc_r & IMASK;
      pad.oe <= drive & ~(odc_r & lat_r);
      pad_cfg.analog <= anlg_r;
      pad_cfg.pull_up <= pu_r;
      pad_cfg.pull_down <= pd_r;
    end
  end

  // Change notice events; a new event wins over a read-clear in the same cycle.
  assign cn_set = (dig_in ^ prev_r) & cnen_r & {16{cncon_r[`PBR_CNCON_ON_BIT]}};
  assign cn_clr = do_read && (s_axi_araddr[15:4] == `PBR_PIN_OFS >> 4);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_r <= 16'h0000;
      cnstat_r <= 16'h0000;
    end
    else
    begin
      prev_r <= dig_in;
      cnstat_r <= ((cn_clr ? 16'h0000 : cnstat_r) | cn_set) & IMASK;
    end
  end

  // Read data selection; alias addresses read the base register.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = is_mapped(s_axi_araddr);
    case (s_axi_araddr[15:4])
      `PBR_ANSEL_OFS >> 4: rd_word[15:0] = anlg_r;
      `PBR_DIR_OFS >> 4: rd_word[15:0] = dir_r;
      `PBR_PIN_OFS >> 4: rd_word[15:0] = dig_in;
      `PBR_LAT_OFS >> 4: rd_word[15:0] = lat_r;
      `PBR_ODC_OFS >> 4: rd_word[15:0] = odc_r;
      `PBR_PU_OFS >> 4: rd_word[15:0] = pu_r;
      `PBR_PD_OFS >> 4: rd_word[15:0] = pd_r;
      `PBR_CNCON_OFS >> 4: rd_word[15:0] = cncon_r;
      `PBR_CNEN_OFS >> 4: rd_word[15:0] = cnen_r;
      `PBR_CNSTAT_OFS >> 4: rd_word[15:0] = cnstat_r;
      default:
      begin
        if (s_axi_araddr[15:5] == `PBR_SEL_PAGE)
          rd_word[`PBR_SEL_W-1:0] = sel_r[s_axi_araddr[4:2]*`PBR_SEL_W +: `PBR_SEL_W];
      end
    endcase
    if (!rd_ok)
      rd_word = 32'h0000_0000;
  end

  // Read channel: one read at a time, data registered on acceptance.
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: src/pbr_map.svh */
`ifndef PBR_MAP_SVH
`define PBR_MAP_SVH
// Port register byte addresses.
`define PBR_ANSEL_OFS 16'h6100
`define PBR_DIR_OFS 16'h6110
`define PBR_PIN_OFS 16'h6120
`define PBR_LAT_OFS 16'h6130
`define PBR_ODC_OFS 16'h6140
`define PBR_PU_OFS 16'h6150
`define PBR_PD_OFS 16'h6160
`define PBR_CNCON_OFS 16'h6170
`define PBR_CNEN_OFS 16'h6180
`define PBR_CNSTAT_OFS 16'h6190
// Alias offsets added to a port register address.
`define PBR_CLR_OFS 4'h4
`define PBR_SET_OFS 4'h8
`define PBR_INV_OFS 4'hC
// Input selection registers, one word per peripheral input.
`define PBR_SEL_BASE 16'h6200
`define PBR_SEL_PAGE 11'h310
`define PBR_NUM_IN 8
`define PBR_SEL_W 4
`define PBR_SEL_NONE 4'hF
// Implemented bit masks and reset values.
`define PBR_MASK_FULL 16'hFFFF
`define PBR_MASK_REDUCED 16'hEFBF
`define PBR_ANSEL_MASK 16'hF00F
`define PBR_ANSEL_RST 16'hE00F
`define PBR_ZERO_RST 16'h0000
`define PBR_CNCON_MASK 16'hA000
`define PBR_CNCON_ON_BIT 15
`define PBR_CNCON_IDLE_BIT 13
`endif

/* File: src/pbr_pkg.sv */
package pbr_pkg;
  typedef logic [3:0] pbr_sel_t;
  typedef enum logic [1:0] {
    pbr_op_base = 2'h0,
    pbr_op_clr = 2'h1,
    pbr_op_set = 2'h2,
    pbr_op_inv = 2'h3
  } pbr_op_t;
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pbr_pad_t;
  typedef struct packed {
    logic [15:0] analog;
    logic [15:0] pull_up;
    logic [15:0] pull_down;
  } pbr_pad_cfg_t;
endpackage

/* File: src/pbr_input_router.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbr_map.svh"
module pbr_input_router (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] pin_level,
  input wire logic [15:0] pin_usable,
  input wire logic [`PBR_NUM_IN*`PBR_SEL_W-1:0] sel_flat,
  output logic [`PBR_NUM_IN-1:0] periph_in,
  output logic [15:0] pin_claimed
);
  logic [15:0] hit [`PBR_NUM_IN];
  // Each peripheral input decodes its own field into a one-hot pin choice.
  genvar k;
  generate
    for (k = 0; k < `PBR_NUM_IN; k++)
    begin : g_in
      pbr_pkg::pbr_sel_t code;
      assign code = sel_flat[k*`PBR_SEL_W +: `PBR_SEL_W];
      // The unassigned code selects no pin at all.
      assign hit[k] = (code == `PBR_SEL_NONE) ? 16'h0000 :
        ((16'h0001 << code) & pin_usable);
      // The routed level is registered toward the peripheral.
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          periph_in[k] <= 1'b0;
        else
          periph_in[k] <= |(hit[k] & pin_level);
      end
    end
  endgenerate
  // A pin is claimed while any peripheral input has selected it and the pin is implemented and not analog-selected.
  always_comb
  begin
    pin_claimed = 16'h0000;
    for (int i = 0; i < `PBR_NUM_IN; i++)
      pin_claimed = pin_claimed | hit[i];
  end
endmodule
`default_nettype wire

/* File: testbench/pbr_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Board side of the port: an outside source drives every pin that the block leaves free.
module pbr_pins_model (
  input wire pbr_pkg::pbr_pad_t pad,
  input wire logic [15:0] ext,
  output logic [15:0] pin_in
);
  // A pin driven by the block shows the block's value, otherwise the outside level.
  assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext);
endmodule
`default_nettype wire

/* File: testbench/pbr_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches bus answers and the configuration copies of the port block.
module pbr_port_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pbr_pkg::pbr_pad_cfg_t pad_cfg
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Read answers come one cycle after the address and hold until taken.
  property p_rd_up; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_rd_up: assert property (p_rd_up) else $error("read upper half not zero");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_rd_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rd_end: assert property (p_rd_end) else $error("read answer repeated");
  // Write answers come two edges after both halves are taken together, then hold until taken.
  property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  property p_wr_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_wr_end: assert property (p_wr_end) else $error("write answer repeated");
  // Unimplemented analog select bits never show on the pads.
  property p_ana_gap; pad_cfg.analog[11:4] == 8'h00; endproperty
  a_ana_gap: assert property (p_ana_gap) else $error("analog gap bits set");
endmodule
bind pbr_port pbr_port_checker pbr_port_checker_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pad_cfg);
`default_nettype wire

/* File: testbench/tb_pbr_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pbr_port;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic [15:0] awa = 16'h0000;
  logic [15:0] ara = 16'h0000;
  logic [15:0] ext = 16'h0000;
  logic [31:0] wd = 32'h00000000;
  logic awr, wr_r, bv, arr, rv;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rdv;
  logic [15:0] pin_in, e, v;
  logic [7:0] periph_in, pexp;
  logic [3:0] k;
  pbr_pkg::pbr_pad_t pad;
  pbr_pkg::pbr_pad_cfg_t pad_cfg;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  pbr_port pbr_port_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .pin_in(pin_in), .pad(pad), .pad_cfg(pad_cfg), .periph_in(periph_in));
  pbr_pins_model pbr_pins_model_i (.pad(pad), .ext(ext), .pin_in(pin_in));
  // Free running bus clock.
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write one word; the answer is accepted only after it has been seen.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr)
        awv <= 1'b0;
      if (wr_r)
        wv <= 1'b0;
      if (bv)
        br <= 1'b1;
    end
    while (!(bv && br));
    br <= 1'b0;
    rsp = bresp;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr)
        arv <= 1'b0;
      if (rv)
        rr <= 1'b1;
    end
    while (!(rv && rr));
    rr <= 1'b0;
    rsp = rresp;
    rdv = rdata;
  endtask
  function automatic logic [15:0] alias_f(input logic [15:0] o, input logic [15:0] m, input int op);
    case (op)
      1: return o & ~m;
      2: return o | m;
      default: return o ^ m;
    endcase
  endfunction
  // Main sequence.
  initial
  begin
    void'($urandom(28));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int r = 0; r < 10; r++)
    begin
      if (r == 2 || r == 3)
        continue;
      rd(16'h6100 + 16'(r * 16));
      chk(rdv, r == 0 ? 32'h0000E00F : r == 1 ? 32'h0000FFFF : 32'h0);
    end
    chk(periph_in, 8'h00);
    $display("reset values done");
    rd(16'h6004);
    chk(rsp, 2'h2);
    chk(rdv, 32'h0);
    wr(16'h6122, 32'h1);
    chk(rsp, 2'h2);
    wr(16'h6190, 32'hFFFF);
    rd(16'h6190);
    chk(rdv, 32'h0);
    v = $urandom;
    wr(16'h6100, {16'hFFFF, v});
    rd(16'h6100);
    chk(rdv, {16'h0, v & 16'hF00F});
    wr(16'h6104, 32'hFFFF);
    rd(16'h6100);
    chk(rdv, 32'h0);
    $display("bus access done");
    e = $urandom;
    wr(16'h6150, {16'hFFFF, e});
    for (int op = 1; op < 4; op++)
    begin
      v = $urandom;
      wr(16'h6150 + 16'(4 * op), {16'hA5A5, v});
      e = alias_f(e, v, op);
      rd(16'h6150 + 16'(4 * op));
      chk(rdv, {16'h0, e});
    end
    chk(pad_cfg.pull_up, e);
    v = $urandom;
    wr(16'h6160, {16'h0, v});
    rd(16'h6160);
    chk(pad_cfg.pull_down, v);
    $display("alias access done");
    v = $urandom;
    wr(16'h6110, 32'h0);
    wr(16'h6130, v);
    rd(16'h6120);
    chk({pad.oe, pad.out}, {16'hFFFF, v});
    wr(16'h6148, 32'hFFFF);
    rd(16'h6130);
    chk({pad.oe, pad.out}, {~v, 16'h0});
    wr(16'h6144, 32'hFFFF);
    wr(16'h6118, 32'hFFFF);
    $display("output drive done");
    @(posedge aclk);
    ext <= $urandom;
    repeat (8) @(posedge aclk);
    rd(16'h6120);
    chk(rdv, {16'h0, ext});
    for (int p = 0; p < 8; p++)
    begin
      k = 4'($urandom_range(14));
      wr(16'h6200 + 16'(4 * p), {28'h0, k});
      pexp[p] = ext[k];
    end
    repeat (8) @(posedge aclk);
    chk(periph_in, pexp);
    wr(16'h6200, 32'hF);
    repeat (8) @(posedge aclk);
    chk(periph_in[0], 1'b0);
    $display("input routing done");
    // Change notice: enabled pins that toggle set status; a pin value read clears it.
    wr(16'h6170, 32'h8000);
    wr(16'h6180, 32'hFFFF);
    v = $urandom;
    ext <= ext ^ v;
    repeat (8) @(posedge aclk);
    rd(16'h6190);
    chk(rdv, {16'h0, v});
    rd(16'h6120);
    rd(16'h6190);
    chk(rdv, 32'h0);
    $display("change notice done");
    // An analog-selected pin reads zero on the digital path.
    wr(16'h6108, 32'h1);
    repeat (8) @(posedge aclk);
    rd(16'h6120);
    chk(rdv, {16'h0, ext & 16'hFFFE});
    chk(pad_cfg.analog, 16'h0001);
    $display("analog cut done");
    finish_test();
  end
endmodule
`default_nettype wire
